// ---- include/mfpm_pkg.sv ----
package mfpm_pkg;
  // register byte addresses on the apb slave
  localparam logic [7:0] ADDR_PIN_FUNC = 8'h00;
  localparam logic [7:0] ADDR_PRT_MODE = 8'h04;
  localparam logic [7:0] ADDR_CFG24 = 8'h08;
  localparam logic [7:0] ADDR_CFG26 = 8'h0C;
  localparam logic [7:0] ADDR_GP_SEL = 8'h10;
  localparam logic [7:0] ADDR_GP_DATA = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  // printer unit mode field
  localparam logic [1:0] MODE_PRINTER = 2'h0;
  localparam logic [1:0] MODE_EXT_FDD = 2'h1;
  localparam logic [1:0] MODE_EXT_2FDD = 2'h2;
  // strap bit positions and the handshake cts status bit
  localparam int CFG24_CLR_BIT = 0;
  localparam int CFG24_KBC_BIT = 2;
  localparam int CFG24_CLK_BIT = 6;
  localparam int CFG26_ADDR_BIT = 6;
  localparam int HS_CTS_BIT = 4;
  // reset values of cfg24, cfg26 and the default function enables (held apart from cfg24)
  localparam logic [7:0] CFG24_DEFAULT = 8'h00;
  localparam logic [7:0] CFG26_DEFAULT = 8'h00;
  localparam logic [7:0] FUNC_EN_DEFAULT = 8'h0F;
  // game port pin selection codes
  localparam logic [1:0] GSEL_GAME = 2'h0;
  localparam logic [1:0] GSEL_GPIO = 2'h1;
  localparam logic [1:0] GSEL_KBC = 2'h2;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYC = FLASH_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 26;
endpackage

// ---- src/mfpm_pin_mux.sv ----
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module mfpm_pin_mux #(
  parameter int FLASH_COUNT = mfpm_pkg::FLASH_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // parallel data pins
  input wire logic [7:0] i_pd,
  output logic [7:0] o_pd,
  output logic [7:0] o_pd_oe_n,
  output logic [7:0] o_pd_pullup,
  input wire logic [7:0] i_prt_data,
  input wire logic i_prt_drive,
  input wire logic i_ext_motor_a,
  input wire logic i_ext_drive_sel_a,
  output logic o_ext_read_data_in,
  output logic o_ext_disk_changed_in,
  // serial strap pins
  input wire logic i_request_to_send_a,
  input wire logic i_terminal_ready_a,
  input wire logic i_serial_out_a,
  input wire logic i_serial_out_b,
  output logic [3:0] o_strap_pulldown,
  input wire logic i_clear_to_send_a,
  input wire logic i_clear_to_send_b,
  output logic [7:0] o_hs_status_a,
  output logic [7:0] o_hs_status_b,
  // keyboard controller and acpi
  input wire logic i_kbc_p21,
  input wire logic i_kbc_p20,
  output logic o_addr20_gate_out,
  output logic o_kbd_reset_out,
  input wire logic i_panel_switch_req,
  output logic o_panel_switch_out,
  input wire logic i_beep,
  output logic o_beep,
  input wire logic i_chassis_intrusion_in,
  input wire logic i_battery_ok,
  input wire logic i_temp_two_over,
  input wire logic i_temp_three_over,
  output logic o_overtemp_shutdown_out,
  // game port / gpio
  input wire logic [7:0] i_game,
  input wire logic [7:0] i_game_func,
  input wire logic [4:0] i_kbc_p1,
  output logic [7:0] o_game,
  output logic [7:0] o_game_oe_n,
  output logic [7:0] o_gp1_in,
  input wire logic i_watchdog,
  output logic o_gp24,
  output logic o_power_led_out,
  // port 3
  input wire logic i_power_fail,
  input wire logic i_vcc_good,
  input wire logic i_vsb_good,
  input wire logic i_suspend,
  input wire logic i_consumer_ir_rx_in,
  output logic o_power_control_out,
  output logic o_power_good_out,
  output logic o_resume_reset_out,
  output logic o_suspend_led_out,
  output logic o_wake,
  output logic [7:0] o_func_en,
  output logic o_kbd_ctrl_enable_bit,
  output logic o_clock_sel_bit,
  output logic o_cfg_port_addr_strap
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [1:0] cts1;
    logic [1:0] cts2;
    logic [4:0] in1;
    logic [4:0] in2;
    logic por_s1;
    logic por_s2;
    logic por_d;
    logic [7:0] pin_func;
    logic [1:0] prt_mode;
    logic [7:0] cfg24;
    logic [7:0] cfg26;
    logic [15:0] gsel;
    logic [7:0] gp_data;
    logic [3:0] ctrl;
    logic [7:0] func_en;
    logic intrusion;
    logic [7:0] pulse_cnt;
    logic psw_d;
    logic [mfpm_pkg::CNT_W-1:0] flash_cnt;
    logic flash;
    logic a20;
    logic kbd_reset_out;
    logic beep;
    logic ir_d;
    logic wake;
  } mfpm_state_t;

  mfpm_state_t st;
  mfpm_state_t next_st;
  logic wr;
  logic ext_mode;
  logic dual_mode;

  assign ext_mode = (st.prt_mode == mfpm_pkg::MODE_EXT_FDD) ||
                    (st.prt_mode == mfpm_pkg::MODE_EXT_2FDD);
  assign dual_mode = st.prt_mode == mfpm_pkg::MODE_EXT_2FDD;
  assign wr = i_psel && i_penable && i_pwrite;

  always_comb begin
    next_st = st;
    // synchronisers: stage 1 feeds stage 2 only
    next_st.s1 = {i_request_to_send_a, i_terminal_ready_a,
                  i_serial_out_a, i_serial_out_b};
    next_st.s2 = st.s1;
    next_st.cts1 = {i_clear_to_send_a, i_clear_to_send_b};
    next_st.cts2 = st.cts1;
    next_st.in1 = {i_chassis_intrusion_in, i_panel_switch_req,
                   i_consumer_ir_rx_in, i_pd[4], i_pd[3]};
    next_st.in2 = st.in1;
    // por is an unclocked pin: two flops before the edge detect
    next_st.por_s1 = i_por;
    next_st.por_s2 = st.por_s1;
    next_st.por_d = st.por_s2;
    // straps sampled on the falling edge of power-on reset
    if (st.por_d && !st.por_s2) begin
      next_st.cfg26[mfpm_pkg::CFG26_ADDR_BIT] = st.s2[3];
      next_st.cfg24[mfpm_pkg::CFG24_CLR_BIT] = st.s2[2];
      next_st.cfg24[mfpm_pkg::CFG24_KBC_BIT] = st.s2[1];
      next_st.cfg24[mfpm_pkg::CFG24_CLK_BIT] = st.s2[0];
      next_st.func_en = st.s2[2] ? 8'h00 : mfpm_pkg::FUNC_EN_DEFAULT;
    end
    if (wr) begin
      case (i_paddr)
        mfpm_pkg::ADDR_PIN_FUNC: next_st.pin_func = i_pwdata[7:0];
        mfpm_pkg::ADDR_PRT_MODE: next_st.prt_mode = i_pwdata[1:0];
        mfpm_pkg::ADDR_CFG24: next_st.cfg24 = i_pwdata[7:0];
        mfpm_pkg::ADDR_CFG26: next_st.cfg26 = i_pwdata[7:0];
        mfpm_pkg::ADDR_GP_SEL: next_st.gsel = i_pwdata[15:0];
        mfpm_pkg::ADDR_GP_DATA: next_st.gp_data = i_pwdata[7:0];
        mfpm_pkg::ADDR_CTRL: next_st.ctrl = i_pwdata[3:0];
        mfpm_pkg::ADDR_STATUS: begin
          if (i_pwdata[0]) begin
            next_st.intrusion = 1'b0;
          end
          if (i_pwdata[1]) begin
            next_st.wake = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // set beats clear; latch kept only while battery present
    if (!st.in2[4]) begin
      next_st.intrusion = 1'b1;
    end
    if (!i_battery_ok) begin
      next_st.intrusion = 1'b0;
    end
    next_st.a20 = i_kbc_p21;
    next_st.kbd_reset_out = i_kbc_p20;
    next_st.beep = i_beep;
    // one fixed-length low pulse per rising request
    next_st.psw_d = st.in2[3];
    if (st.in2[3] && !st.psw_d) begin
      next_st.pulse_cnt = 8'(mfpm_pkg::PULSE_CYC);
    end else if (st.pulse_cnt != 8'h00) begin
      next_st.pulse_cnt = st.pulse_cnt - 8'h01;
    end
    if (st.flash_cnt == '0) begin
      next_st.flash_cnt = mfpm_pkg::CNT_W'(FLASH_COUNT - 1);
      next_st.flash = ~st.flash;
    end else begin
      next_st.flash_cnt = st.flash_cnt - 1'b1;
    end
    next_st.ir_d = st.in2[2];
    if (st.ir_d && !st.in2[2] && st.ctrl[3]) begin
      next_st.wake = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
      st.cfg24 <= mfpm_pkg::CFG24_DEFAULT;
      st.cfg26 <= mfpm_pkg::CFG26_DEFAULT;
      st.func_en <= mfpm_pkg::FUNC_EN_DEFAULT;
      st.a20 <= 1'b1;
      st.kbd_reset_out <= 1'b1;
      st.beep <= 1'b0;
      st.s2 <= '0;
      // idle levels; panel switch idles low so no false pulse follows reset
      st.in1 <= 5'h17;
      st.in2 <= 5'h17;
      st.ir_d <= 1'b1;
      st.flash_cnt <= mfpm_pkg::CNT_W'(FLASH_COUNT - 1);
    end else begin
      st <= next_st;
    end
  end

  // parallel data pin mux; open drain outputs drive only low
  always_comb begin
    o_pd = i_prt_data;
    o_pd_oe_n = i_prt_drive ? 8'h00 : 8'hFF;
    o_pd_pullup = 8'h00;
    if (ext_mode) begin
      o_pd_oe_n[3] = 1'b1;
      o_pd_oe_n[4] = 1'b1;
      o_pd_pullup[4:3] = 2'b11;
      o_pd_oe_n[5] = 1'b1;
      o_pd_oe_n[7:6] = 2'b11;
      o_pd[7:5] = 3'b000;
      if (dual_mode) begin
        o_pd_oe_n[6] = i_ext_motor_a;
        o_pd_oe_n[7] = i_ext_drive_sel_a;
      end
    end
  end
  assign o_ext_read_data_in = ext_mode ? st.in2[0] : 1'b1;
  assign o_ext_disk_changed_in = ext_mode ? st.in2[1] : 1'b1;
  // weak pulldowns only while reset holds; pins revert afterwards
  assign o_strap_pulldown = st.por_s2 ? 4'hF : 4'h0;

  assign o_hs_status_a = {3'h0, ~st.cts2[1], 4'h0};
  assign o_hs_status_b = {3'h0, ~st.cts2[0], 4'h0};

  assign o_addr20_gate_out = st.a20;
  assign o_kbd_reset_out = st.kbd_reset_out;
  assign o_beep = st.beep;
  assign o_panel_switch_out = st.pulse_cnt == 8'h00;
  assign o_overtemp_shutdown_out =
    !(i_temp_two_over || i_temp_three_over);

  // game port selection, two bits per pin
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      o_game[k] = i_game_func[k];
      o_game_oe_n[k] = 1'b1;
      case (st.gsel[2*k +: 2])
        mfpm_pkg::GSEL_GAME: begin
          o_game[k] = i_game_func[k];
          o_game_oe_n[k] = 1'b1;
        end
        mfpm_pkg::GSEL_GPIO: begin
          o_game[k] = 1'b0;
          o_game_oe_n[k] = st.gp_data[k];
        end
        mfpm_pkg::GSEL_KBC: begin
          o_game[k] = 1'b0;
          o_game_oe_n[k] = (k < 5) ? i_kbc_p1[k % 5] : 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
  assign o_gp1_in = i_game;
  assign o_gp24 = st.ctrl[0] ? i_watchdog : st.ctrl[1];
  assign o_power_led_out = st.ctrl[2];

  assign o_power_control_out = !i_power_fail;
  assign o_power_good_out = i_vcc_good;
  assign o_resume_reset_out = i_vsb_good;
  assign o_suspend_led_out = i_suspend ? st.flash : 1'b1;
  assign o_wake = st.wake;
  assign o_func_en = st.func_en;
  assign o_kbd_ctrl_enable_bit = st.cfg24[mfpm_pkg::CFG24_KBC_BIT];
  assign o_clock_sel_bit = st.cfg24[mfpm_pkg::CFG24_CLK_BIT];
  assign o_cfg_port_addr_strap = st.cfg26[mfpm_pkg::CFG26_ADDR_BIT];

  assign o_pready = 1'b1;
  always_comb begin
    o_pslverr = 1'b0;
    case (i_paddr)
      mfpm_pkg::ADDR_PIN_FUNC: o_prdata = {24'h0, st.pin_func};
      mfpm_pkg::ADDR_PRT_MODE: o_prdata = {30'h0, st.prt_mode};
      mfpm_pkg::ADDR_CFG24: o_prdata = {24'h0, st.cfg24};
      mfpm_pkg::ADDR_CFG26: o_prdata = {24'h0, st.cfg26};
      mfpm_pkg::ADDR_GP_SEL: o_prdata = {16'h0, st.gsel};
      mfpm_pkg::ADDR_GP_DATA: o_prdata = {24'h0, st.gp_data};
      mfpm_pkg::ADDR_CTRL: o_prdata = {28'h0, st.ctrl};
      mfpm_pkg::ADDR_STATUS:
        o_prdata = {24'h0, ~st.cts2[1], ~st.cts2[0], 4'h0,
                    st.wake, st.intrusion};
      default: begin
        o_prdata = 32'h0;
        o_pslverr = i_psel && i_penable;
      end
    endcase
  end

  AST_A20_RESET: assert property (@(posedge i_clk)
    $past(i_rst) |-> o_addr20_gate_out)
    else $error("address gate not high after reset");
  AST_KBD_RESET_OUT_RESET: assert property (@(posedge i_clk)
    $past(i_rst) |-> o_kbd_reset_out)
    else $error("keyboard reset not high after reset");
  AST_BEEP_RESET: assert property (@(posedge i_clk)
    $past(i_rst) |-> !o_beep)
    else $error("beep not low after reset");
  AST_POWER_LED_OUT_RESET: assert property (@(posedge i_clk)
    $past(i_rst) |-> !o_power_led_out)
    else $error("power led not low after reset");
  AST_OVT: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (i_temp_two_over || i_temp_three_over) |-> !o_overtemp_shutdown_out)
    else $error("overtemp not asserted");
  AST_PULSE: assert property (@(posedge i_clk)
    disable iff (i_rst)
    $fell(o_panel_switch_out) |-> ##[1:200] o_panel_switch_out)
    else $error("panel switch output stuck low");
  AST_EXT_TRI: assert property (@(posedge i_clk)
    disable iff (i_rst)
    ext_mode |-> o_pd_oe_n[5] && o_pd_oe_n[4] && o_pd_oe_n[3])
    else $error("extension input pin driven");
  AST_STRAP: assert property (@(posedge i_clk)
    disable iff (i_rst)
    $fell(st.por_s2) |=> o_kbd_ctrl_enable_bit == $past(st.s2[1]))
    else $error("strap not captured");
  AST_INTR: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (!st.in2[4] && i_battery_ok) |=> st.intrusion)
    else $error("intrusion not latched");
  AST_DUAL_MOTOR: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (dual_mode && !i_ext_motor_a) |-> !o_pd_oe_n[6] && !o_pd[6])
    else $error("extension motor output not driven low");
  AST_DUAL_SEL: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (dual_mode && !i_ext_drive_sel_a) |-> !o_pd_oe_n[7] && !o_pd[7])
    else $error("extension select output not driven low");
  AST_EXT_PULLUP: assert property (@(posedge i_clk)
    disable iff (i_rst)
    ext_mode |-> o_pd_pullup[4:3] == 2'b11)
    else $error("extension inputs not pulled up");
  AST_WAKE: assert property (@(posedge i_clk)
    disable iff (i_rst)
    ($fell(st.in2[2]) && st.ctrl[3]) |=> o_wake)
    else $error("ir wake not latched");
  COV_EXT2: cover property (@(posedge i_clk) dual_mode);
  COV_STRAP: cover property (@(posedge i_clk) $fell(i_por));
  COV_PULSE: cover property (@(posedge i_clk) !o_panel_switch_out);
  COV_WAKE: cover property (@(posedge i_clk) o_wake);
  COV_INTR: cover property (@(posedge i_clk) st.intrusion);
endmodule

// ---- sim/mfpm_far_model.sv ----
`timescale 1ns/1ps
module mfpm_far_model (
  input wire logic i_clk,
  input wire logic [7:0] i_pd_out,
  input wire logic [7:0] i_pd_oe_n,
  input wire logic [7:0] i_pd_pullup,
  input wire logic [7:0] i_drv_en,
  input wire logic [7:0] i_drv_val,
  output logic [7:0] o_pad
);
  logic [7:0] noise = 8'h55;
  // a floating pin keeps changing so a stale level is never mistaken
  always @(posedge i_clk) noise <= ~noise;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!i_pd_oe_n[b])
        o_pad[b] = i_pd_out[b];
      else if (i_drv_en[b])
        o_pad[b] = i_drv_val[b];
      else if (i_pd_pullup[b])
        o_pad[b] = 1'b1;
      else
        o_pad[b] = noise[b];
    end
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic i_clk, i_rst, i_por, i_psel, i_penable, i_pwrite, i_prt_drive;
  logic i_ext_motor_a, i_ext_drive_sel_a, i_request_to_send_a;
  logic i_terminal_ready_a, i_serial_out_a, i_serial_out_b;
  logic i_clear_to_send_a, i_clear_to_send_b, i_kbc_p21, i_kbc_p20;
  logic i_beep, i_panel_switch_req, i_chassis_intrusion_in, i_battery_ok;
  logic i_temp_two_over, i_temp_three_over, i_watchdog, i_power_fail;
  logic i_vcc_good, i_vsb_good, i_suspend, i_consumer_ir_rx_in, err;
  logic [7:0] i_paddr, i_prt_data, i_game, i_game_func, drv_en, drv_val;
  logic [4:0] i_kbc_p1;
  logic [31:0] i_pwdata, o_prdata, rd;
  wire [7:0] i_pd;
  logic o_pready, o_pslverr, o_ext_read_data_in, o_ext_disk_changed_in;
  logic o_addr20_gate_out, o_kbd_reset_out, o_panel_switch_out, o_beep;
  logic o_overtemp_shutdown_out, o_gp24, o_power_led_out, o_wake;
  logic o_power_control_out, o_power_good_out, o_resume_reset_out;
  logic o_suspend_led_out, o_kbd_ctrl_enable_bit, o_clock_sel_bit;
  logic o_cfg_port_addr_strap;
  logic [7:0] o_pd, o_pd_oe_n, o_pd_pullup, o_hs_status_a, o_hs_status_b;
  logic [7:0] o_game, o_game_oe_n, o_gp1_in, o_func_en;
  logic [3:0] o_strap_pulldown;
  int mismatches, checked, cyc;

  mfpm_pin_mux #(.FLASH_COUNT(4)) i_mfpm_pin_mux (.*);
  mfpm_far_model i_mfpm_far_model (.i_clk(i_clk), .i_pd_out(o_pd),
    .i_pd_oe_n(o_pd_oe_n), .i_pd_pullup(o_pd_pullup), .i_drv_en(drv_en),
    .i_drv_val(drv_val), .o_pad(i_pd));

  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string n, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // called at a rising edge; checks are read there too, before it updates
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    n = 0;
    // no wait limit here: the bench timeout ends a hung transfer
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    chk("access cycles", n, 1);
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_clk);
  endtask

  task automatic t_strap(input logic [3:0] s);
    i_por <= 1;
    {i_request_to_send_a, i_terminal_ready_a, i_serial_out_a,
     i_serial_out_b} <= s;
    tick(4);
    chk("pulldown", o_strap_pulldown, 4'hF);
    i_por <= 0;
    tick(6);
    // pins go back to serial traffic; no second capture may follow
    {i_request_to_send_a, i_terminal_ready_a, i_serial_out_a,
     i_serial_out_b} <= ~s;
    tick(4);
    chk("addr", o_cfg_port_addr_strap, s[3]);
    chk("func", o_func_en, s[2] ? 8'h00 : mfpm_pkg::FUNC_EN_DEFAULT);
    chk("kbc", o_kbd_ctrl_enable_bit, s[1]);
    chk("clk", o_clock_sel_bit, s[0]);
    chk("release", o_strap_pulldown, 4'h0);
    apb(0, mfpm_pkg::ADDR_CFG24, 0);
    chk("cfg24", {rd[6], rd[2], rd[0]}, {s[0], s[1], s[2]});
    apb(0, mfpm_pkg::ADDR_CFG26, 0);
    chk("cfg26", rd[6], s[3]);
  endtask

  task automatic t_mode;
    i_prt_drive <= 1;
    i_prt_data <= 8'hA5;
    drv_en <= 8'h18;
    for (int m = 0; m < 3; m++) begin
      apb(1, mfpm_pkg::ADDR_PRT_MODE, 32'(m));
      drv_val <= m[0] ? 8'h08 : 8'h10;
      i_ext_motor_a <= 0;
      i_ext_drive_sel_a <= 1;
      tick(4);
      if (m == 0) begin
        chk("prt oe", o_pd_oe_n, 8'h00);
        chk("prt pd", o_pd, 8'hA5);
        chk("rd idle", o_ext_read_data_in, 1);
      end else begin
        chk("oe543", o_pd_oe_n[5:3], 3'h7);
        chk("pullup", o_pd_pullup[4:3], 2'h3);
        chk("rdata", o_ext_read_data_in, drv_val[3]);
        chk("dskchg", o_ext_disk_changed_in, drv_val[4]);
        chk("oe76", o_pd_oe_n[7:6], m == 1 ? 2'h3 : 2'h2);
      end
    end
    i_ext_motor_a <= 1;
    i_ext_drive_sel_a <= 0;
    tick(2);
    chk("sel", {o_pd_oe_n[7:6], o_pd[7]}, 3'b010);
    apb(1, mfpm_pkg::ADDR_PRT_MODE, 32'(mfpm_pkg::MODE_PRINTER));
  endtask

  task automatic t_misc;
    for (int i = 0; i < 4; i++) begin
      {i_temp_two_over, i_temp_three_over} <= i[1:0];
      {i_power_fail, i_vcc_good, i_vsb_good} <= {i[0], i[1], i[0] ^ i[1]};
      tick(1);
      chk("ovt", o_overtemp_shutdown_out, i == 0);
      chk("port3", {o_power_control_out, o_power_good_out,
          o_resume_reset_out}, {~i[0], i[1], i[0] ^ i[1]});
    end
    i_game <= 8'h3C;
    i_game_func <= 8'h5A;
    i_kbc_p1 <= 5'h0A;
    apb(1, mfpm_pkg::ADDR_GP_DATA, 32'h60);
    chk("game dflt", o_game, 8'h5A);
    chk("game dflt oe", o_game_oe_n, 8'hFF);
    apb(1, mfpm_pkg::ADDR_GP_SEL, 32'h56AA);
    chk("gp1", o_gp1_in, 8'h3C);
    chk("game oe", o_game_oe_n, 8'h6A);
    chk("game alt", o_game, 8'h00);
    apb(1, mfpm_pkg::ADDR_CTRL, 32'h6);
    chk("power_led_out", o_power_led_out, 1);
    chk("gp24", o_gp24, 1);
    apb(1, mfpm_pkg::ADDR_CTRL, 32'h3);
    chk("wdt", o_gp24, 0);
  endtask

  task automatic t_status;
    int n;
    logic p;
    i_chassis_intrusion_in <= 0;
    i_clear_to_send_a <= 0;
    tick(1);
    i_chassis_intrusion_in <= 1;
    tick(4);
    chk("cts", {o_hs_status_a[4], o_hs_status_b[4]}, 2'b10);
    apb(0, mfpm_pkg::ADDR_STATUS, 0);
    chk("status", rd[7:0], 8'h81);
    apb(1, mfpm_pkg::ADDR_STATUS, 1);
    apb(0, mfpm_pkg::ADDR_STATUS, 0);
    chk("w1c", rd[0], 0);
    apb(1, mfpm_pkg::ADDR_CTRL, 32'h8);
    i_consumer_ir_rx_in <= 0;
    tick(4);
    i_consumer_ir_rx_in <= 1;
    chk("wake", o_wake, 1);
    apb(0, 8'h20, 0);
    chk("slverr", err, 1);
    chk("unmapped", rd, 0);
    i_panel_switch_req <= 1;
    n = 0;
    while (o_panel_switch_out !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    n = 0;
    while (o_panel_switch_out === 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
    chk("pulse", n, mfpm_pkg::PULSE_CYC);
    i_panel_switch_req <= 0;
    i_suspend <= 1;
    n = 0;
    p = o_suspend_led_out;
    repeat (40) begin
      tick(1);
      n += (o_suspend_led_out !== p);
      p = o_suspend_led_out;
    end
    chk("flash", n > 4, 1);
  endtask

  initial begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_prt_data} = '0;
    {i_prt_drive, i_request_to_send_a, i_terminal_ready_a} = '0;
    {i_serial_out_a, i_serial_out_b, i_kbc_p21, i_kbc_p20} = '0;
    {i_panel_switch_req, i_temp_two_over, i_temp_three_over} = '0;
    {i_watchdog, i_power_fail, i_vcc_good, i_vsb_good, i_suspend} = '0;
    {i_game, i_game_func, i_kbc_p1, drv_en, drv_val} = '0;
    {i_rst, i_por, i_beep, i_chassis_intrusion_in, i_battery_ok} = '1;
    {i_clear_to_send_a, i_clear_to_send_b, i_consumer_ir_rx_in} = '1;
    {i_ext_motor_a, i_ext_drive_sel_a} = '1;
    tick(2);
    i_rst <= 0;
    chk("a20", o_addr20_gate_out, 1);
    chk("kbd_reset_out", o_kbd_reset_out, 1);
    chk("beep", o_beep, 0);
    chk("pled0", o_power_led_out, 0);
    tick(2);
    chk("a20 copy", {o_addr20_gate_out, o_kbd_reset_out}, 0);
    t_strap(4'b1010);
    t_strap(4'b0101);
    t_mode();
    t_misc();
    t_status();
    results();
  end
endmodule
